// ---- tpgc_cfg.svh ----
// Contract
// - dual mode counts up, toggles on match
// - reload raises interrupt, count restarts 0001H
// - polarity one: starts high, low on match
// - polarity zero: starts low, high on match
// - dual mode drives true and complement pins
// - deadband delays rising edges in dual mode only, 0 to 128
// - single pwm duty set by polarity
// - odd start count only shapes first period
// - gated start count only first pass
// - gated interrupt source selectable
// - capture starts on first qualifying edge
// - later edges copy count into pwm register
// - capture interrupts, restarts count at 0001H
// - capture sets capture cause flag
// - compare timeout interrupts, clears cause flag
`ifndef TPGC_CFG_SVH
`define TPGC_CFG_SVH
// ==========================================
// register word offsets (byte address bits 5:2)
`define TPGC_OFS_CTL 4'h0
`define TPGC_OFS_CTL2 4'h1
`define TPGC_OFS_COUNT 4'h2
`define TPGC_OFS_RELOAD 4'h3
`define TPGC_OFS_PWM 4'h4
`define TPGC_OFS_DEAD 4'h5
`define TPGC_OFS_STAT 4'h6
`define TPGC_OFS_MASK 4'h7
// ==========================================
// control field positions
`define TPGC_CTL_EN 7
`define TPGC_CTL_POL 6
`define TPGC_CTL_MODE_LSB 3
`define TPGC_CTL2_MODEHI 7
`define TPGC_CTL2_CAP 0
`define TPGC_CTL2_ISRC_LSB 1
// ==========================================
// reset values and deadband limit
`define TPGC_COUNT_RST 16'h0001
`define TPGC_RELOAD_RST 16'hFFFF
`define TPGC_DEAD_MAX 8'h80
`endif

// ---- tpgc_dead.sv ----
`timescale 1ns/10ps
`default_nettype none
module tpgc_dead #(
  parameter int DW = 8
) (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // sync reset
  input wire logic in_i, // raw pwm level
  input wire logic [DW-1:0] dead_i, // rising edge delay
  output logic out_o // delayed level
);
  logic [DW-1:0] cnt_reg;
  // deadband up to 128 needs eight bits
  if (DW < 8)
  begin : g_dw_check
    $error("tpgc_dead width too small");
  end
  // falls at once, rises after dead_i cycles of steady high
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !in_i)
    begin
      cnt_reg <= '0;
      out_o <= 1'b0;
    end
    else if (cnt_reg >= dead_i)
      out_o <= 1'b1;
    else
      cnt_reg <= cnt_reg + 1'b1;
  end
endmodule : tpgc_dead
`default_nettype wire

// ---- tpgc_pin_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module tpgc_pin_model (
  input wire logic clk_i, // clock
  input wire logic run_i, // toggling on
  output logic pin_o // timer input level
);
  // ==========================================
  // square wave, ten cycles per half period
  logic [3:0] cnt = 4'h0;
  initial pin_o = 1'b0;
  always @(posedge clk_i)
  begin
    cnt <= (run_i && cnt != 4'h9) ? cnt + 4'h1 : 4'h0;
    if (run_i && cnt == 4'h9)
      pin_o <= !pin_o;
  end
endmodule : tpgc_pin_model
`default_nettype wire

// ---- tpgc_pkg.sv ----
package tpgc_pkg;
  typedef enum logic [3:0] {
    TPGC_ONESHOT = 4'h0,
    TPGC_CONT = 4'h1,
    TPGC_PWM = 4'h3,
    TPGC_CAPCMP = 4'h5,
    TPGC_GATED = 4'h6,
    TPGC_DUAL = 4'h8
  } tpgc_mode_e;
  typedef enum logic [1:0] {
    TPGC_INT_BOTH = 2'h0,
    TPGC_INT_DEASSERT = 2'h2,
    TPGC_INT_RELOAD = 2'h3
  } tpgc_isrc_e;
endpackage : tpgc_pkg

// ---- tpgc_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
module tpgc_sync (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // sync reset
  input wire logic d_i, // async pin
  output logic q_o // synchronised level
);
  logic meta_reg;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_reg <= 1'b0;
      q_o <= 1'b0;
    end
    else
    begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule : tpgc_sync
`default_nettype wire

// ---- tpgc_timer.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "tpgc_cfg.svh"
module tpgc_timer (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // sync reset
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // write enable
  input wire logic [5:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  input wire logic timer_input_pin_i, // external timer input
  output logic timer_output_pin_o, // true pwm output
  output logic timer_output_pin_n_o, // complement output
  output logic irq_o // level interrupt
);
  import tpgc_pkg::*;
  // ==========================================
  // registers
  logic [7:0] ctl_reg;
  logic mode_upper_bit_reg;
  logic [1:0] isrc_reg;
  logic capture_cause_flag_reg;
  logic [15:0] count_reg;
  logic [15:0] reload_reg;
  logic [15:0] pwm_reg;
  logic [7:0] dead_reg;
  logic [2:0] stat_reg;
  logic [2:0] mask_reg;
  logic out_reg;
  logic started_reg;
  logic in_d_reg;
  logic ack_reg;
  logic [31:0] rdat_reg;
  // ==========================================
  // decode
  wire [3:0] word_w = wb_adr_i[5:2];
  wire req_w = wb_cyc_i && wb_stb_i && !ack_reg;
  wire wr_w = req_w && wb_we_i && wb_sel_i[0];
  wire wr16_w = req_w && wb_we_i && (wb_sel_i[1:0] == 2'b11);
  wire enable_w = ctl_reg[`TPGC_CTL_EN];
  wire pol_w = ctl_reg[`TPGC_CTL_POL];
  wire [3:0] mode_w = {mode_upper_bit_reg, ctl_reg[`TPGC_CTL_MODE_LSB+:3]};
  wire dual_w = mode_w == TPGC_DUAL;
  wire single_w = mode_w == TPGC_PWM;
  wire gated_w = mode_w == TPGC_GATED;
  wire capcmp_w = mode_w == TPGC_CAPCMP;
  wire pwm_any_w = dual_w || single_w;
  // ==========================================
  // timer input
  logic in_s;
  tpgc_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(timer_input_pin_i),
    .q_o(in_s)
  );
  wire rise_w = in_s && !in_d_reg;
  wire fall_w = !in_s && in_d_reg;
  wire edge_ok_w = pol_w ? fall_w : rise_w;
  wire run_w = enable_w && (gated_w ? in_s : (capcmp_w ? started_reg : 1'b1));
  wire at_reload_w = run_w && (count_reg == reload_reg);
  wire at_match_w = run_w && pwm_any_w && (count_reg == pwm_reg);
  wire capture_w = enable_w && capcmp_w && started_reg && edge_ok_w;
  wire deassert_w = enable_w && gated_w && fall_w;
  wire rl_int_w = at_reload_w && !(gated_w && isrc_reg == TPGC_INT_DEASSERT);
  wire de_int_w = deassert_w && (isrc_reg != TPGC_INT_RELOAD);
  wire [2:0] ev_w = {capture_w, de_int_w, rl_int_w && !capture_w};
  // ==========================================
  // counter
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      count_reg <= `TPGC_COUNT_RST;
      started_reg <= 1'b0;
      in_d_reg <= 1'b0;
    end
    else
    begin
      in_d_reg <= in_s;
      if (!enable_w)
        started_reg <= 1'b0;
      else if (capcmp_w && edge_ok_w)
        started_reg <= 1'b1;
      if (wr16_w && word_w == `TPGC_OFS_COUNT)
        count_reg <= wb_dat_i[15:0];
      else if (capture_w || at_reload_w)
        count_reg <= `TPGC_COUNT_RST;
      else if (run_w)
        count_reg <= count_reg + 16'h0001;
    end
  end
  // ==========================================
  // pwm output level
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      out_reg <= 1'b0;
    else if (!enable_w || !pwm_any_w)
      out_reg <= pol_w;
    else if (at_reload_w)
      out_reg <= pol_w;
    else if (at_match_w)
      out_reg <= !out_reg;
  end
  // ==========================================
  // deadband pair
  logic true_d;
  logic comp_d;
  tpgc_dead #(.DW(8)) u_dead_t (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_i(out_reg),
    .dead_i(dual_w ? dead_reg : 8'h00),
    .out_o(true_d)
  );
  tpgc_dead #(.DW(8)) u_dead_c (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_i(!out_reg && dual_w),
    .dead_i(dead_reg),
    .out_o(comp_d)
  );
  assign timer_output_pin_o = true_d;
  assign timer_output_pin_n_o = comp_d;
  // ==========================================
  // register writes
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctl_reg <= 8'h00;
      mode_upper_bit_reg <= 1'b0;
      isrc_reg <= TPGC_INT_BOTH;
      capture_cause_flag_reg <= 1'b0;
      reload_reg <= `TPGC_RELOAD_RST;
      pwm_reg <= 16'h0000;
      dead_reg <= 8'h00;
      stat_reg <= 3'h0;
      mask_reg <= 3'h0;
    end
    else
    begin
      if (wr_w && word_w == `TPGC_OFS_CTL)
        ctl_reg <= wb_dat_i[7:0];
      if (wr_w && word_w == `TPGC_OFS_CTL2)
      begin
        mode_upper_bit_reg <= wb_dat_i[`TPGC_CTL2_MODEHI];
        isrc_reg <= wb_dat_i[`TPGC_CTL2_ISRC_LSB+:2];
      end
      if (capture_w)
        capture_cause_flag_reg <= 1'b1;
      else if (at_reload_w && capcmp_w)
        capture_cause_flag_reg <= 1'b0;
      if (wr16_w && word_w == `TPGC_OFS_RELOAD)
        reload_reg <= wb_dat_i[15:0];
      if (capture_w)
        pwm_reg <= count_reg;
      else if (wr16_w && word_w == `TPGC_OFS_PWM)
        pwm_reg <= wb_dat_i[15:0];
      if (wr_w && word_w == `TPGC_OFS_DEAD)
        dead_reg <= (wb_dat_i[7:0] > `TPGC_DEAD_MAX) ? `TPGC_DEAD_MAX : wb_dat_i[7:0];
      if (wr_w && word_w == `TPGC_OFS_MASK)
        mask_reg <= wb_dat_i[2:0];
      // set wins over write-one-to-clear
      if (wr_w && word_w == `TPGC_OFS_STAT)
        stat_reg <= (stat_reg & ~wb_dat_i[2:0]) | ev_w;
      else
        stat_reg <= stat_reg | ev_w;
    end
  end
  assign irq_o = |(stat_reg & mask_reg);
  // ==========================================
  // read mux and ack
  logic [31:0] rmux_w;
  always_comb
  begin
    case (word_w)
      `TPGC_OFS_CTL: rmux_w = {24'h000000, ctl_reg};
      `TPGC_OFS_CTL2: rmux_w = {24'h000000, mode_upper_bit_reg, 4'h0, isrc_reg,
        capture_cause_flag_reg};
      `TPGC_OFS_COUNT: rmux_w = {16'h0000, count_reg};
      `TPGC_OFS_RELOAD: rmux_w = {16'h0000, reload_reg};
      `TPGC_OFS_PWM: rmux_w = {16'h0000, pwm_reg};
      `TPGC_OFS_DEAD: rmux_w = {24'h000000, dead_reg};
      `TPGC_OFS_STAT: rmux_w = {29'h00000000, stat_reg};
      `TPGC_OFS_MASK: rmux_w = {29'h00000000, mask_reg};
      default: rmux_w = 32'h00000000;
    endcase
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg <= 1'b0;
      rdat_reg <= 32'h00000000;
    end
    else
    begin
      ack_reg <= req_w;
      rdat_reg <= rmux_w;
    end
  end
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;
endmodule : tpgc_timer
`default_nettype wire

// ---- tpgc_timer_checker.sv ----
`timescale 1ns/10ps
`default_nettype none
module tpgc_timer_checker (
  input wire logic clk_i, // clock
  input wire logic rst_i, // reset
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write
  input wire logic [5:0] wb_adr_i, // address
  input wire logic [31:0] wb_dat_o, // read data
  input wire logic wb_ack_o, // ack
  input wire logic timer_output_pin_o, // pwm
  input wire logic timer_output_pin_n_o, // pwm complement
  input wire logic irq_o // interrupt
);
  // ==========================================
  // bus and output checks
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_rd;
    wb_ack_o && !wb_we_i;
  endsequence
  property p_ack_next; s_req |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("ack missing");
  property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_one: assert property (p_ack_one)
    else $error("ack too long");
  property p_ack_cause; $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i); endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without request");
  property p_unmapped; s_rd ##0 wb_adr_i[5] |-> wb_dat_o == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_upper; s_rd |-> wb_dat_o[31:16] == 16'h0; endproperty
  a_upper: assert property (p_upper)
    else $error("upper read bits set");
  property p_no_overlap; !(timer_output_pin_o && timer_output_pin_n_o); endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("both outputs active");
  property p_irq_fall; $fell(irq_o) |-> wb_ack_o && wb_we_i; endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("irq dropped without write");
  property p_rst_quiet; $fell(rst_i) |-> !(wb_ack_o || irq_o || timer_output_pin_o); endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("outputs busy after reset");
endmodule : tpgc_timer_checker
bind tpgc_timer tpgc_timer_checker u_chk (.*);
`default_nettype wire

// ---- tpgc_timer_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tpgc_timer_tb;
  logic clk_i = 0;
  logic rst_i = 1;
  logic cyc = 0;
  logic we = 0;
  logic run = 0;
  logic [5:0] adr = 0;
  logic [31:0] wd = 0;
  logic [31:0] rd;
  logic [31:0] v;
  logic ack, pin, out, outn, irq;
  int bad_count = 0;
  int num_checks = 0;
  int hi;
  initial forever #10 clk_i = !clk_i;
  tpgc_timer DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rd),
    .wb_ack_o(ack), .timer_input_pin_i(pin), .timer_output_pin_o(out),
    .timer_output_pin_n_o(outn), .irq_o(irq));
  tpgc_pin_model u_pin (.clk_i(clk_i), .run_i(run), .pin_o(pin));
  // ==========================================
  // tasks
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value %s exp %0h got %0h", s, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= {a, 2'b00};
    wd <= d;
    do
      @(posedge clk_i);
    while (ack !== 1'b1 && n++ < 50);
    v = rd;
    cyc <= 1'b0;
    chk("ack", 1, ack);
    if (n >= 50)
      complete_run();
  endtask : bus
  task automatic rc(input logic [3:0] a, input logic [31:0] e, input string s);
    bus(1'b0, a, 32'h0);
    chk(s, e, v);
  endtask : rc
  task automatic pw(input logic [1:0] e);
    @(negedge clk_i);
    chk("outputs", e, {out, outn});
  endtask : pw
  task automatic ci(input logic e);
    @(negedge clk_i);
    chk("irq", e, irq);
  endtask : ci
  task automatic wirq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n++ < 400)
      @(negedge clk_i);
    chk("irq wait", 1, irq);
    if (n >= 400)
      complete_run();
  endtask : wirq
  // ==========================================
  // tests
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rc(4'h2, 32'h1, "count");
    rc(4'h3, 32'hFFFF, "reload");
    rc(4'h8, 32'h0, "unmapped");
    $display("test reset done");
    for (int p = 0; p < 2; p++)
    begin
      bus(1, 4'h0, p << 6);
      bus(1, 4'h1, 32'h80);
      bus(1, 4'h3, 20);
      bus(1, 4'h4, 8);
      bus(1, 4'h5, 2);
      bus(1, 4'h7, 1);
      bus(1, 4'h6, 7);
      bus(1, 4'h2, 1);
      bus(1, 4'h0, 32'h80 | (p << 6));
      repeat (5) @(negedge clk_i);
      pw({p[0], !p[0]});
      repeat (7) @(negedge clk_i);
      pw({!p[0], p[0]});
      wirq();
      bus(1, 4'h0, 0);
      bus(1, 4'h7, 0);
      ci(0);
      bus(1, 4'h7, 1);
      ci(1);
      bus(1, 4'h6, 1);
      ci(0);
      $display("test dual pwm done");
    end
    for (int p = 0; p < 2; p++)
    begin
      bus(1, 4'h0, p << 6);
      bus(1, 4'h1, 0);
      bus(1, 4'h5, 0);
      bus(1, 4'h4, 5);
      bus(1, 4'h2, 1);
      bus(1, 4'h0, 32'h98 | (p << 6));
      repeat (30) @(negedge clk_i);
      hi = 0;
      repeat (60) @(negedge clk_i) hi += out;
      chk("duty", p ? 15 : 45, hi);
      bus(1, 4'h0, 0);
      $display("test single pwm done");
    end
    bus(1, 4'h1, 32'h4);
    bus(1, 4'h3, 5);
    bus(1, 4'h2, 3);
    bus(1, 4'h6, 7);
    bus(1, 4'h7, 2);
    bus(1, 4'h0, 32'hB0);
    run <= 1'b1;
    wirq();
    run <= 1'b0;
    rc(4'h2, 32'h3, "gated count");
    rc(4'h6, 32'h2, "gated status");
    bus(1, 4'h0, 0);
    bus(1, 4'h1, 0);
    $display("test gated done");
    bus(1, 4'h2, 1);
    bus(1, 4'h3, 32'h1000);
    bus(1, 4'h6, 7);
    bus(1, 4'h7, 4);
    bus(1, 4'h0, 32'hA8);
    run <= 1'b1;
    wirq();
    run <= 1'b0;
    rc(4'h1, 32'h1, "cause");
    rc(4'h4, 20, "capture");
    bus(1, 4'h3, 200);
    bus(1, 4'h7, 1);
    bus(1, 4'h6, 7);
    wirq();
    rc(4'h1, 32'h0, "cause");
    $display("test capture done");
    complete_run();
  end
endmodule : tpgc_timer_tb
`default_nettype wire
